/* rtl/dsbio_decoder.sv */
// Purpose: Decoder for the branch, I/O, data-move and control instruction groups.
// Assumes: Words arrive with IVALID_I; status inputs are valid with the first word.
// Notes:   All outputs are registered; results appear one edge after the word.
// What this block does
// RL1: Fixed opcode jumps to the address held in the low accumulator.
// RL2: Two-word jump taken only when the selected auxiliary register is nonzero.
// RL3: Two-word jump taken only when no overflow is flagged.
// RL4: Two-word jump taken only when the general-purpose input pin is low.
// RL5: Two-word opcode copies a block from data memory to data memory.
// RL6: Two-word opcode copies a block from program memory to data memory.
// RL7: Format opcode loads the serial word-length bit from its lowest bit.
// RL8: Port read and write opcodes; bits 11 to 8 pick one of sixteen ports.
// RL9: Two opcodes clear or set serial frame-synchronisation mode.
// RL10: Two opcodes clear or set the serial transmit framing mode.
// RL11: Bit test picks the bit by temporary register and sets the test flag.
// RL12: Two opcodes map the on-chip block into data or program space.
// RL13: Opcodes load the first or second status register from memory.
// RL14: Opcodes store the first or second status register into memory.
// RL15: Pop stack to memory, and push a memory word onto the stack.
// RL16: Push low accumulator onto stack, or pop stack into low accumulator.
// RL17: Repeat counter loads from an 8-bit immediate or from data memory.
// RL18: Bit test never writes the accumulator.
// RL19: Two-word instructions take their second word as address before finishing.
// RL20: Bit 7 selects indirect addressing; otherwise a 7-bit direct offset.
`timescale 1ns/1ps
module dsbio_decoder
  import dsbio_pkg::*;
(
  input  wire logic         CLK_I,
  input  wire logic         RESET_I,
  input  wire logic [15:0]  IWORD_I,
  input  wire logic         IVALID_I,
  input  wire logic [15:0]  ACC_LOW_I,
  input  wire logic         AUX_NONZERO_I,
  input  wire logic         OVERFLOW_I,
  input  wire logic         IO_PIN_I,
  input  wire logic [15:0]  TREG_I,
  input  wire logic [15:0]  DMEM_I,
  output dsbio_op_t         OP_O,
  output logic              OP_VALID_O,
  output logic              BUSY_O,
  output logic              JUMP_O,
  output logic [15:0]       TARGET_O,
  output logic [3:0]        PORT_O,
  output dsbio_mem_t        MEM_O,
  output logic [7:0]        REPEAT_COUNT_O,
  output logic              ACC_WE_O,
  output logic              TEST_FLAG_O,
  output logic              WORD_LEN_O,
  output logic              FSYNC_O,
  output logic              TXM_O,
  output logic              BLK_DATA_O
);

  // Map a first word to its operation; the function is called in one place.
  function automatic dsbio_op_t decode(input logic [15:0] w);
    dsbio_op_t op;
    op = OP_NONE;
    if (w == OPC_JACC)                          op = OP_JACC; // RL1
    else if (w[15:1] == OPC_FMT_HI)             op = OP_FMT;  // RL7
    else if (w == OPC_FSM_CLR || w == OPC_FSM_SET) op = OP_FSM;  // RL9
    else if (w == OPC_TXM_CLR || w == OPC_TXM_SET) op = OP_TXM;  // RL10
    else if (w == OPC_CNF_DATA || w == OPC_CNF_PROG) op = OP_CNF; // RL12
    else if (w == OPC_PUSH_ACC)                 op = OP_PUSH; // RL16
    else if (w == OPC_POP_ACC)                  op = OP_POP;  // RL16
    else begin
      unique case (w[15:8])
        PFX_JANZ: op = OP_JANZ; // RL2
        PFX_JNOV: op = OP_JNOV; // RL3
        PFX_JIO:  op = OP_JIO;  // RL4
        PFX_BDD:  op = OP_BDD;  // RL5
        PFX_BPD:  op = OP_BPD;  // RL6
        PFX_TBIT:    op = OP_TBIT;    // RL11
        PFX_LDSTAT1: op = OP_LDSTAT1; // RL13
        PFX_LDSTAT2: op = OP_LDSTAT2; // RL13
        PFX_SVSTAT1: op = OP_SVSTAT1; // RL14
        PFX_SVSTAT2: op = OP_SVSTAT2; // RL14
        PFX_STK2MEM: op = OP_STK2MEM; // RL15
        PFX_MEM2STK: op = OP_MEM2STK; // RL15
        PFX_REPIMM:  op = OP_REPIMM;  // RL17
        PFX_REPMEM:  op = OP_REPMEM;  // RL17
        default: begin
          if (w[15:12] == PFX_IN)       op = OP_IN;  // RL8
          else if (w[15:12] == PFX_OUT) op = OP_OUT; // RL8
        end
      endcase
    end
    return op;
  endfunction : decode

  // Two-word forms wait for an address word.
  function automatic logic two_word(input dsbio_op_t op);
    return op inside {OP_JANZ, OP_JNOV, OP_JIO, OP_BDD, OP_BPD};
  endfunction : two_word

  dsbio_state_t state_r;
  dsbio_state_t state_nxt;
  dsbio_op_t    first_op;
  dsbio_op_t    held_op_r;
  logic         held_cond_r;
  logic         cond_now;
  logic         take_first;
  logic         take_second;
  logic [3:0]   bit_sel;

  assign first_op    = decode(IWORD_I);
  assign take_first  = IVALID_I && state_r == ST_FIRST;
  assign take_second = IVALID_I && state_r == ST_SECOND;
  assign bit_sel     = BIT_TOP - TREG_I[3:0];

  // Branch conditions are sampled with the first word, when status is current.
  always_comb begin
    unique case (first_op)
      OP_JANZ: cond_now = AUX_NONZERO_I; // RL2
      OP_JNOV: cond_now = !OVERFLOW_I;   // RL3
      OP_JIO:  cond_now = !IO_PIN_I;     // RL4
      default: cond_now = 1'b0;
    endcase
  end

  // Sequencer: a two-word opcode parks here until its address word comes.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_FIRST:  if (take_first && two_word(first_op)) state_nxt = ST_SECOND; // RL19
      ST_SECOND: if (IVALID_I) state_nxt = ST_FIRST;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= ST_FIRST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Held operation and branch outcome between the two words.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      held_op_r   <= OP_NONE;
      held_cond_r <= 1'b0;
    end else if (take_first) begin
      held_op_r   <= first_op;
      held_cond_r <= cond_now;
    end
  end

  // Issue: single-word ops on their word, two-word ops on the address word.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      OP_O       <= OP_NONE;
      OP_VALID_O <= 1'b0;
      JUMP_O     <= 1'b0;
      TARGET_O   <= 16'h0000;
    end else begin
      OP_VALID_O <= 1'b0;
      JUMP_O     <= 1'b0;
      if (take_second) begin
        OP_O       <= held_op_r;
        OP_VALID_O <= 1'b1;
        JUMP_O     <= held_cond_r; // RL2 RL3 RL4
        TARGET_O   <= IWORD_I;     // RL19 RL5 RL6
      end else if (take_first && !two_word(first_op)) begin
        OP_O       <= first_op;
        OP_VALID_O <= 1'b1;
        if (first_op == OP_JACC) begin
          JUMP_O   <= 1'b1;      // RL1
          TARGET_O <= ACC_LOW_I; // RL1
        end
      end
    end
  end

  // The one-hot second-word bit is the flop itself, so no gate sits on the output.
  assign BUSY_O = state_r[1];

  // Operand fields of the first word.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PORT_O      <= 4'h0;
      MEM_O       <= '0;
      REPEAT_COUNT_O <= 8'h00;
    end else if (take_first) begin
      PORT_O         <= IWORD_I[11:8]; // RL8
      MEM_O.indirect <= IWORD_I[IND_BIT]; // RL20
      MEM_O.field    <= IWORD_I[6:0];     // RL20
      REPEAT_COUNT_O <= IWORD_I[7:0];     // RL17
    end
  end

  // Only the pop into the low accumulator writes it; bit test never does.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ACC_WE_O <= 1'b0;
    end else begin
      ACC_WE_O <= take_first && first_op == OP_POP; // RL16 RL18
    end
  end

  // Test flag from the data bit picked by the temporary register.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      TEST_FLAG_O <= 1'b0;
    end else if (take_first && first_op == OP_TBIT) begin
      TEST_FLAG_O <= DMEM_I[bit_sel]; // RL11
    end
  end

  // Serial port and memory map modes keep state until changed.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      WORD_LEN_O <= WLEN_RST;
      FSYNC_O    <= FSYNC_RST;
      TXM_O      <= TXM_RST;
      BLK_DATA_O <= BLK_DATA_RST;
    end else if (take_first) begin
      unique case (first_op)
        OP_FMT:  WORD_LEN_O <= IWORD_I[0];  // RL7
        OP_FSM:  FSYNC_O    <= IWORD_I[0];  // RL9
        OP_TXM:  TXM_O      <= IWORD_I[0];  // RL10
        OP_CNF:  BLK_DATA_O <= !IWORD_I[0]; // RL12
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // Assertions tie outputs except OP_O, FSYNC_O, TXM_O, REPEAT_COUNT_O and MEM_O.field to their cause one edge earlier.
  jacc_target_a: assert property (take_first && first_op == OP_JACC |=> // RL1
    JUMP_O && TARGET_O == $past(ACC_LOW_I)) else $error("acc jump wrong");
  janz_cond_a: assert property (take_first && first_op == OP_JANZ && !AUX_NONZERO_I // RL2
    ##1 IVALID_I |=> !JUMP_O) else $error("aux jump taken on zero");
  jnov_cond_a: assert property (take_first && first_op == OP_JNOV && !OVERFLOW_I // RL3
    ##1 IVALID_I |=> JUMP_O) else $error("no-overflow jump missed");
  jio_cond_a: assert property (take_first && first_op == OP_JIO && IO_PIN_I // RL4
    ##1 IVALID_I |=> !JUMP_O) else $error("pin jump taken on high");
  second_word_a: assert property (take_first && two_word(first_op) |=> // RL19
    !OP_VALID_O && BUSY_O) else $error("two-word op issued early");
  block_addr_a: assert property (take_second |=> OP_VALID_O && // RL5
    TARGET_O == $past(IWORD_I)) else $error("block address wrong");
  fmt_bit_a: assert property (take_first && first_op == OP_FMT |=> // RL7
    WORD_LEN_O == $past(IWORD_I[0])) else $error("format bit wrong");
  port_sel_a: assert property (take_first && first_op inside {OP_IN, OP_OUT} |=> // RL8
    PORT_O == $past(IWORD_I[11:8])) else $error("port wrong");
  tbit_acc_a: assert property (take_first && first_op == OP_TBIT |=> // RL18
    !ACC_WE_O && TEST_FLAG_O == $past(DMEM_I[bit_sel])) else $error("bit test wrong");
  cnf_map_a: assert property (take_first && IWORD_I == OPC_CNF_PROG |=> // RL12
    !BLK_DATA_O) else $error("block map wrong");
  mem_mode_a: assert property (take_first |=> // RL20
    MEM_O.indirect == $past(IWORD_I[IND_BIT])) else $error("address mode wrong");

endmodule : dsbio_decoder

/* rtl/dsbio_pkg.sv */
// Purpose: Shared constants and types for the branch, I/O and control decoder.
// Assumes: 16-bit instruction words, one clock.
// Notes:   Prefixes are the top eight opcode bits, except PFX_IN and PFX_OUT, which are the top four.
package dsbio_pkg;
  localparam int          WORD_W       = 16;
  localparam logic [15:0] OPC_JACC     = 16'hCE25;
  localparam logic [14:0] OPC_FMT_HI   = 15'h6707;
  localparam logic [15:0] OPC_FSM_CLR  = 16'hCE36;
  localparam logic [15:0] OPC_FSM_SET  = 16'hCE37;
  localparam logic [15:0] OPC_TXM_CLR  = 16'hCE20;
  localparam logic [15:0] OPC_TXM_SET  = 16'hCE21;
  localparam logic [15:0] OPC_CNF_DATA = 16'hCE04;
  localparam logic [15:0] OPC_CNF_PROG = 16'hCE05;
  localparam logic [15:0] OPC_PUSH_ACC = 16'hCE1C;
  localparam logic [15:0] OPC_POP_ACC  = 16'hCE1D;
  localparam logic [7:0]  PFX_JANZ     = 8'hFB;
  localparam logic [7:0]  PFX_JNOV     = 8'hF7;
  localparam logic [7:0]  PFX_JIO      = 8'hFA;
  localparam logic [7:0]  PFX_BDD      = 8'hFD;
  localparam logic [7:0]  PFX_BPD      = 8'hFC;
  localparam logic [7:0]  PFX_TBIT     = 8'h57;
  localparam logic [7:0]  PFX_LDSTAT1  = 8'h50;
  localparam logic [7:0]  PFX_LDSTAT2  = 8'h51;
  localparam logic [7:0]  PFX_SVSTAT1  = 8'h78;
  localparam logic [7:0]  PFX_SVSTAT2  = 8'h79;
  localparam logic [7:0]  PFX_STK2MEM  = 8'h7A;
  localparam logic [7:0]  PFX_MEM2STK  = 8'h54;
  localparam logic [7:0]  PFX_REPIMM   = 8'hCB;
  localparam logic [7:0]  PFX_REPMEM   = 8'h4B;
  localparam logic [3:0]  PFX_IN       = 4'h8;
  localparam logic [3:0]  PFX_OUT      = 4'hE;
  localparam int          IND_BIT      = 7;
  localparam logic [3:0]  BIT_TOP      = 4'hF;
  localparam logic        WLEN_RST     = 1'b0;
  localparam logic        FSYNC_RST    = 1'b0;
  localparam logic        TXM_RST      = 1'b0;
  localparam logic        BLK_DATA_RST = 1'b1;

  // Decoded operation codes.
  typedef enum logic [4:0] {
    OP_NONE, OP_JACC, OP_JANZ, OP_JNOV, OP_JIO, OP_BDD, OP_BPD,
    OP_FMT, OP_IN, OP_OUT, OP_FSM, OP_TXM, OP_TBIT, OP_CNF,
    OP_LDSTAT1, OP_LDSTAT2, OP_SVSTAT1, OP_SVSTAT2, OP_STK2MEM, OP_MEM2STK,
    OP_PUSH, OP_POP, OP_REPIMM, OP_REPMEM
  } dsbio_op_t;

  // Memory operand: indirect flag and the low seven opcode bits.
  typedef struct packed {
    logic       indirect;
    logic [6:0] field;
  } dsbio_mem_t;

  // Decoder sequencing, one-hot.
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } dsbio_state_t;
endpackage : dsbio_pkg

/* tb/dsbio_decoder_tb_top.sv */
// Purpose: Self-checking bench for the branch, I/O and control decoder.
// Assumes: Outputs settle one edge after the word that completes an op.
// Notes:   A row with a nonzero second word is sent as a two-word op.
`timescale 1ns/1ps
module dsbio_decoder_tb_top;
  import dsbio_pkg::*;

  typedef struct {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [2:0]  st;
    logic [3:0]  tr;
    dsbio_op_t   op;
    logic        jmp;
    logic [3:0]  md;
    logic        tc;
  } dsbio_row_t;

  logic        clk;
  logic        rst;
  logic        aux;
  logic        ovf;
  logic        pin;
  logic [15:0] treg;
  logic [15:0] iword;
  logic        ivalid;
  logic [15:0] acc = 16'h1357;
  logic [15:0] dmem = 16'h1000;
  dsbio_op_t   OP_O;
  logic        OP_VALID_O, BUSY_O, JUMP_O, ACC_WE_O, TEST_FLAG_O;
  logic        WORD_LEN_O, FSYNC_O, TXM_O, BLK_DATA_O;
  logic [15:0] TARGET_O;
  logic [3:0]  PORT_O;
  dsbio_mem_t  MEM_O;
  logic [7:0]  REPEAT_COUNT_O;
  int          n_fail, total_checks, i, j;
  dsbio_row_t  r;
  logic [15:0] seq[5] = '{16'hCE0F, 16'hCE37, 16'hCE21, 16'hCE05, 16'hFB80};
  dsbio_op_t   seq_op[4] = '{OP_FMT, OP_FSM, OP_TXM, OP_CNF};
  dsbio_row_t  rows[32] = '{
    '{16'hCE25,16'h0,3'h0,4'h0,OP_JACC,1'h1,4'h1,1'h0}, '{16'hFB80,16'h1234,3'h4,4'h0,OP_JANZ,1'h1,4'h1,1'h0},
    '{16'hFB05,16'h2222,3'h0,4'h0,OP_JANZ,1'h0,4'h1,1'h0}, '{16'hF780,16'h3333,3'h0,4'h0,OP_JNOV,1'h1,4'h1,1'h0},
    '{16'hF700,16'h4444,3'h2,4'h0,OP_JNOV,1'h0,4'h1,1'h0}, '{16'hFA80,16'h5555,3'h0,4'h0,OP_JIO,1'h1,4'h1,1'h0},
    '{16'hFA00,16'h6666,3'h1,4'h0,OP_JIO,1'h0,4'h1,1'h0}, '{16'hFD81,16'h0100,3'h0,4'h0,OP_BDD,1'h0,4'h1,1'h0},
    '{16'hFC02,16'h0200,3'h0,4'h0,OP_BPD,1'h0,4'h1,1'h0}, '{16'hCE0F,16'h0,3'h0,4'h0,OP_FMT,1'h0,4'h9,1'h0},
    '{16'hCE0E,16'h0,3'h0,4'h0,OP_FMT,1'h0,4'h1,1'h0}, '{16'h8A85,16'h0,3'h0,4'h0,OP_IN,1'h0,4'h1,1'h0},
    '{16'hE37F,16'h0,3'h0,4'h0,OP_OUT,1'h0,4'h1,1'h0}, '{16'hCE37,16'h0,3'h0,4'h0,OP_FSM,1'h0,4'h5,1'h0},
    '{16'hCE36,16'h0,3'h0,4'h0,OP_FSM,1'h0,4'h1,1'h0}, '{16'hCE21,16'h0,3'h0,4'h0,OP_TXM,1'h0,4'h3,1'h0},
    '{16'hCE20,16'h0,3'h0,4'h0,OP_TXM,1'h0,4'h1,1'h0}, '{16'hCE05,16'h0,3'h0,4'h0,OP_CNF,1'h0,4'h0,1'h0},
    '{16'hCE04,16'h0,3'h0,4'h0,OP_CNF,1'h0,4'h1,1'h0}, '{16'h5781,16'h0,3'h0,4'h3,OP_TBIT,1'h0,4'h1,1'h1},
    '{16'h5702,16'h0,3'h0,4'h4,OP_TBIT,1'h0,4'h1,1'h0}, '{16'h5012,16'h0,3'h0,4'h0,OP_LDSTAT1,1'h0,4'h1,1'h0},
    '{16'h5193,16'h0,3'h0,4'h0,OP_LDSTAT2,1'h0,4'h1,1'h0}, '{16'h7804,16'h0,3'h0,4'h0,OP_SVSTAT1,1'h0,4'h1,1'h0},
    '{16'h79F5,16'h0,3'h0,4'h0,OP_SVSTAT2,1'h0,4'h1,1'h0}, '{16'h7A06,16'h0,3'h0,4'h0,OP_STK2MEM,1'h0,4'h1,1'h0},
    '{16'h5477,16'h0,3'h0,4'h0,OP_MEM2STK,1'h0,4'h1,1'h0}, '{16'hCE1C,16'h0,3'h0,4'h0,OP_PUSH,1'h0,4'h1,1'h0},
    '{16'hCE1D,16'h0,3'h0,4'h0,OP_POP,1'h0,4'h1,1'h0}, '{16'hCB2A,16'h0,3'h0,4'h0,OP_REPIMM,1'h0,4'h1,1'h0},
    '{16'h4B8B,16'h0,3'h0,4'h0,OP_REPMEM,1'h0,4'h1,1'h0}, '{16'h5500,16'h0,3'h0,4'h0,OP_NONE,1'h0,4'h1,1'h0}};

  dsbio_decoder dsbio_decoder_i (.CLK_I(clk), .RESET_I(rst), .IWORD_I(iword), .IVALID_I(ivalid),
    .ACC_LOW_I(acc), .AUX_NONZERO_I(aux), .OVERFLOW_I(ovf), .IO_PIN_I(pin), .TREG_I(treg),
    .DMEM_I(dmem), .OP_O(OP_O), .OP_VALID_O(OP_VALID_O), .BUSY_O(BUSY_O), .JUMP_O(JUMP_O),
    .TARGET_O(TARGET_O), .PORT_O(PORT_O), .MEM_O(MEM_O), .REPEAT_COUNT_O(REPEAT_COUNT_O),
    .ACC_WE_O(ACC_WE_O), .TEST_FLAG_O(TEST_FLAG_O), .WORD_LEN_O(WORD_LEN_O), .FSYNC_O(FSYNC_O), .TXM_O(TXM_O),
    .BLK_DATA_O(BLK_DATA_O));

  dsbio_prog_mem dsbio_prog_mem_i (.clk_i(clk), .rst_i(rst), .word_o(iword), .valid_o(ivalid));

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Compare with four-state equality so an unknown never counts as a match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print the counts and the verdict, then stop.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // Wait a bounded time for an issue pulse; a hang ends the run as a failure.
  task automatic wait_op();
    int k;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      if (OP_VALID_O === 1'h1) return;
    end
    n_fail++;
    $display("mismatch at %0t: no issue seen", $time);
    final_report();
  endtask : wait_op

  // Main sequence: table of ordinary ops, then back-to-back, reset and slow fetch.
  initial begin
    rst = 1'h1;
    {aux, ovf, pin} = 3'h0;
    treg = 16'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      {aux, ovf, pin} <= r.st;
      treg <= 16'(r.tr);
      #1;
      dsbio_prog_mem_i.push(r.w0);
      if (r.w1 !== 16'h0) dsbio_prog_mem_i.push(r.w1);
      wait_op();
      check(16'({OP_O, JUMP_O, ACC_WE_O, WORD_LEN_O, FSYNC_O, TXM_O, BLK_DATA_O, TEST_FLAG_O}),
            16'({r.op, r.jmp, r.op == OP_POP, r.md, r.tc}));
      check(16'({PORT_O, MEM_O}), 16'(r.w0[11:0]));
      check(16'(REPEAT_COUNT_O), 16'(r.w0[7:0]));
      if (r.w1 !== 16'h0 || r.op == OP_JACC) check(TARGET_O, (r.w1 !== 16'h0) ? r.w1 : acc);
      $display("row %0d done", i);
    end
    // Back-to-back mode ops, then a first word left waiting when reset hits.
    @(posedge clk);
    #1;
    foreach (seq[j]) dsbio_prog_mem_i.push(seq[j]);
    wait_op();
    for (j = 0; j < 4; j++) begin
      check(16'({OP_VALID_O, OP_O}), 16'({1'h1, seq_op[j]}));
      @(posedge clk);
      #1;
    end
    check(16'({BUSY_O, OP_VALID_O, WORD_LEN_O, FSYNC_O, TXM_O, BLK_DATA_O}), 16'h2E);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    #1;
    check(16'({BUSY_O, OP_VALID_O, OP_O, WORD_LEN_O, FSYNC_O, TXM_O, BLK_DATA_O}), 16'({2'h0, OP_NONE, 4'h1}));
    $display("back-to-back and reset done");
    // Slow fetch: the jump waits for its address word; the condition is held from word one.
    @(posedge clk);
    aux <= 1'h1;
    #1;
    dsbio_prog_mem_i.push(16'hFB80);
    repeat (2) @(posedge clk);
    aux <= 1'h0;
    for (j = 0; j < 4; j++) begin
      @(posedge clk);
      #1;
      check(16'({BUSY_O, OP_VALID_O}), 16'h2);
    end
    dsbio_prog_mem_i.push(16'h0F0F);
    wait_op();
    check(16'({OP_O, JUMP_O}), 16'({OP_JANZ, 1'h1}));
    check(TARGET_O, 16'h0F0F);
    $display("slow fetch done");
    final_report();
  end
endmodule : dsbio_decoder_tb_top

/* tb/dsbio_prog_mem.sv */
// Purpose: Program memory model that hands instruction words to the decoder.
// Assumes: One word per cycle at most; the bench fills the queue between edges.
// Notes:   An empty queue means no fetch, so the word lines show changing junk.
`timescale 1ns/1ps
module dsbio_prog_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  output logic [15:0]      word_o,
  output logic             valid_o
);
  logic [15:0] rom_q[$];

  // Queue a word; the bench calls this away from the clock edge.
  task automatic push(input logic [15:0] w);
    rom_q.push_back(w);
  endtask : push

  // Present one queued word a cycle, in the order the bench pairs them.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'h0;
      word_o  <= 16'hA5A5;
    end else if (rom_q.size() != 0) begin
      valid_o <= 1'h1;
      word_o  <= rom_q.pop_front();
    end else begin
      valid_o <= 1'h0;
      word_o  <= ~word_o; // Idle lines toggle so a stale word cannot look valid.
    end
  end
endmodule : dsbio_prog_mem
